// file: logic/mdt_pkg.sv
package mdt_pkg;

	// Time base: one elapsed-time unit is one tick of TICK_MS.
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES_DFLT = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TICK_W = 17;

	// Least start or reset pulse width that the external source must hold.
	localparam int MIN_PULSE_MS = 50;
	localparam int MIN_PULSE_CYCLES = MIN_PULSE_MS * 1000000 / CLK_PERIOD_NS;

	localparam int SET_W = 16;
	localparam int ELAPSED_W = 17;
	localparam logic [ELAPSED_W-1:0] ELAPSED_ZERO = 17'h00000;
	localparam logic [ELAPSED_W-1:0] ELAPSED_ONE = 17'h00001;
	localparam logic [ELAPSED_W-1:0] ELAPSED_MAX = 17'h1FFFF;
	localparam logic [TICK_W-1:0] TICK_ZERO = 17'h00000;
	localparam logic [TICK_W-1:0] TICK_ONE = 17'h00001;

	typedef enum logic [1:0]
	{
		MODE_ON_DELAY = 2'h0,
		MODE_INTERVAL = 2'h1,
		MODE_FLICKER  = 2'h2,
		MODE_ONE_SHOT = 2'h3
	} mdt_mode_e;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h1,
		ST_RUN  = 3'h2,
		ST_DONE = 3'h4
	} mdt_state_e;

	typedef struct packed
	{
		logic startIn;
		logic resetIn;
		logic gateIn;
	} mdt_pins_s;

	typedef struct packed
	{
		mdt_mode_e          mode;
		logic [SET_W-1:0]   phase1Time;
		logic [SET_W-1:0]   phase2Time;
	} mdt_cfg_s;

endpackage

// file: logic/mdt_core.sv
`timescale 1ns/1ps
// What this block does
// - An active reset input aborts timing and clears elapsed time to zero.
// - Reset stops timing, forces the control output off, returns to idle.
// - Active gate freezes elapsed time, save the flicker wrap to zero on reaching the total; counting resumes from it afterwards.
// - Reaching the set time switches the control output as the mode dictates.
// - One-shot mode gives one pulse per start (none when phase two is zero), however long start stays.
// - In on-delay and flicker modes, a set time of zero switches the output on at once.
// - Two-phase modes use phase one plus phase two as the set time.
// - Start and reset still act while gate is active; only counting stops.
module mdt_core
	import mdt_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DFLT
)
(
	input  wire logic                  mclk,
	input  wire logic                  rst_b,
	input  wire mdt_pins_s             pinsIn,
	input  wire mdt_cfg_s              cfgIn,
	output logic                       ctrlOut,
	output logic [ELAPSED_W-1:0]       elapsedTime
);

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	mdt_pins_s              pinSync1_r;
	mdt_pins_s              pinSync2_r;
	logic                   startPrev_r;
	logic [TICK_W-1:0]      tickCnt_r;
	logic [TICK_W-1:0]      tickCnt_nxt;
	logic                   tick_r;
	mdt_state_e             state_r;
	mdt_state_e             state_nxt;
	logic                   ctrlOut_r;
	logic                   ctrlOut_nxt;
	logic [ELAPSED_W-1:0]   elapsed_r;
	logic [ELAPSED_W-1:0]   elapsed_nxt;

	wire                    startEdge;
	wire                    rstActive;
	wire                    gateActive;
	wire                    tickWrap;
	wire [ELAPSED_W-1:0]    t1Ext;
	wire [ELAPSED_W-1:0]    sumTime;
	wire                    hitT1;
	wire                    hitSum;
	wire                    sumZero;
	wire                    countNow;
	wire [ELAPSED_W-1:0]    elapsedInc;

	// Pins are contacts or sensors from outside; only the second stage is read.
	// Pulses are assumed held for the minimum width, so no debounce filter is kept.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pinSync1_r  <= '0;
			pinSync2_r  <= '0;
			startPrev_r <= 1'b0;
		end
		else
		begin
			pinSync1_r  <= pinsIn;
			pinSync2_r  <= pinSync1_r;
			startPrev_r <= pinSync2_r.startIn;
		end
	end

	assign startEdge  = pinSync2_r.startIn & ~startPrev_r;
	assign rstActive  = pinSync2_r.resetIn;
	assign gateActive = pinSync2_r.gateIn;

	// The prescaler also holds during gate so a paused interval loses no partial tick.
	assign tickWrap = (tickCnt_r == TICK_LAST);
	always_comb
	begin
		tickCnt_nxt = tickCnt_r;
		if (rstActive || startEdge)
			tickCnt_nxt = TICK_ZERO;
		else if (!gateActive)
			tickCnt_nxt = tickWrap ? TICK_ZERO : tickCnt_r + TICK_ONE;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tickCnt_r <= TICK_ZERO;
			tick_r    <= 1'b0;
		end
		else
		begin
			tickCnt_r <= tickCnt_nxt;
			tick_r    <= tickWrap & ~gateActive & ~rstActive & ~startEdge;
		end
	end

	assign t1Ext      = {1'b0, cfgIn.phase1Time};
	assign sumTime    = t1Ext + {1'b0, cfgIn.phase2Time};
	assign hitT1      = (elapsed_r >= t1Ext);
	assign hitSum     = (elapsed_r >= sumTime);
	assign sumZero    = (sumTime == ELAPSED_ZERO);
	assign countNow   = tick_r & ~gateActive & (state_r == ST_RUN) & (elapsed_r != ELAPSED_MAX);
	assign elapsedInc = countNow ? elapsed_r + ELAPSED_ONE : elapsed_r;

	always_comb
	begin
		state_nxt   = state_r;
		ctrlOut_nxt = ctrlOut_r;
		elapsed_nxt = elapsedInc;
		if (rstActive)
		begin
			state_nxt   = ST_IDLE;
			ctrlOut_nxt = 1'b0;
			elapsed_nxt = ELAPSED_ZERO;
		end
		else if (startEdge)
		begin
			state_nxt   = ST_RUN;
			ctrlOut_nxt = 1'b0;
			elapsed_nxt = ELAPSED_ZERO;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
				end
				ST_DONE:
				begin
				end
				ST_RUN:
				begin
					unique case (cfgIn.mode)
						MODE_ON_DELAY:
						begin
							if (hitT1)
							begin
								ctrlOut_nxt = 1'b1;
								state_nxt   = ST_DONE;
							end
						end
						MODE_INTERVAL:
						begin
							ctrlOut_nxt = ~hitT1;
							if (hitT1)
								state_nxt = ST_DONE;
						end
						MODE_FLICKER:
						begin
							// A zero total cannot alternate, so the output simply holds on.
							if (sumZero)
								ctrlOut_nxt = 1'b1;
							else if (hitSum)
							begin
								ctrlOut_nxt = 1'b0;
								elapsed_nxt = ELAPSED_ZERO;
							end
							else
								ctrlOut_nxt = hitT1;
						end
						MODE_ONE_SHOT:
						begin
							if (hitSum)
							begin
								ctrlOut_nxt = 1'b0;
								state_nxt   = ST_DONE;
							end
							else
								ctrlOut_nxt = hitT1;
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r   <= ST_IDLE;
			ctrlOut_r <= 1'b0;
			elapsed_r <= ELAPSED_ZERO;
		end
		else
		begin
			state_r   <= state_nxt;
			ctrlOut_r <= ctrlOut_nxt;
			elapsed_r <= elapsed_nxt;
		end
	end

	assign ctrlOut     = ctrlOut_r;
	assign elapsedTime = elapsed_r;

	property p_startRestart;
		@(posedge mclk) disable iff (!rst_b)
		startEdge && !rstActive |=> elapsed_r == ELAPSED_ZERO && state_r == ST_RUN && !ctrlOut_r;
	endproperty
	a_startRestart: assert property (p_startRestart) else $error("start did not restart");

	property p_resetClears;
		@(posedge mclk) disable iff (!rst_b)
		rstActive |=> elapsed_r == ELAPSED_ZERO && state_r == ST_IDLE;
	endproperty
	a_resetClears: assert property (p_resetClears) else $error("reset did not clear");

	property p_resetOutputOff;
		@(posedge mclk) disable iff (!rst_b)
		rstActive [*2] |-> !ctrlOut_r && state_r == ST_IDLE;
	endproperty
	a_resetOutputOff: assert property (p_resetOutputOff) else $error("output on in reset");

	property p_gateHolds;
		@(posedge mclk) disable iff (!rst_b)
		gateActive && !rstActive && !startEdge && state_r == ST_RUN
			&& !(cfgIn.mode == MODE_FLICKER && hitSum) |=> $stable(elapsed_r);
	endproperty
	a_gateHolds: assert property (p_gateHolds) else $error("elapsed moved under gate");

	property p_onDelayFires;
		@(posedge mclk) disable iff (!rst_b)
		state_r == ST_RUN && cfgIn.mode == MODE_ON_DELAY && hitT1 && !rstActive && !startEdge
			|=> ctrlOut_r && state_r == ST_DONE;
	endproperty
	a_onDelayFires: assert property (p_onDelayFires) else $error("on-delay did not fire");

	property p_oneShotSingle;
		@(posedge mclk) disable iff (!rst_b)
		state_r == ST_DONE && cfgIn.mode == MODE_ONE_SHOT && !rstActive && !startEdge
			|=> !ctrlOut_r && state_r == ST_DONE;
	endproperty
	a_oneShotSingle: assert property (p_oneShotSingle) else $error("second one-shot pulse");

	sequence s_zeroStart;
		startEdge && !rstActive && cfgIn.mode == MODE_ON_DELAY && cfgIn.phase1Time == '0
			##1 !rstActive && !startEdge && cfgIn.mode == MODE_ON_DELAY
			&& cfgIn.phase1Time == '0;
	endsequence
	property p_zeroInstant;
		@(posedge mclk) disable iff (!rst_b)
		s_zeroStart |=> ctrlOut_r;
	endproperty
	a_zeroInstant: assert property (p_zeroInstant) else $error("zero set time not instant");

	property p_flickerWrap;
		@(posedge mclk) disable iff (!rst_b)
		state_r == ST_RUN && cfgIn.mode == MODE_FLICKER && hitSum && !sumZero
			&& !rstActive && !startEdge |=> elapsed_r == ELAPSED_ZERO && state_r == ST_RUN;
	endproperty
	a_flickerWrap: assert property (p_flickerWrap) else $error("flicker did not wrap at sum");

	property p_gateResetWorks;
		@(posedge mclk) disable iff (!rst_b)
		gateActive && rstActive |=> state_r == ST_IDLE && !ctrlOut_r;
	endproperty
	a_gateResetWorks: assert property (p_gateResetWorks) else $error("reset ignored under gate");

	c_onDelayFire: cover property (@(posedge mclk) disable iff (!rst_b)
		state_r == ST_RUN ##1 state_r == ST_DONE && ctrlOut_r);
	c_gatedRun: cover property (@(posedge mclk) disable iff (!rst_b)
		state_r == ST_RUN && gateActive ##1 !gateActive && state_r == ST_RUN);
	c_flickerCycle: cover property (@(posedge mclk) disable iff (!rst_b)
		cfgIn.mode == MODE_FLICKER && ctrlOut_r ##1 !ctrlOut_r && state_r == ST_RUN);
	c_startUnderGate: cover property (@(posedge mclk) disable iff (!rst_b)
		gateActive && startEdge);

endmodule

// file: test/mdt_switch_model.sv
`timescale 1ns/1ps
// Contact model: each start or reset request is stretched to HOLD_CYCLES, a scaled-down width.
module mdt_switch_model
	import mdt_pkg::*;
#(
	parameter int HOLD_CYCLES = 4
)
(
	input  wire logic      mclk,
	input  wire mdt_pins_s reqIn,
	output mdt_pins_s      pinsOut
);
	int        sCnt = 0;
	int        rCnt = 0;
	mdt_pins_s pins_r = '0;
	assign pinsOut = pins_r;
	always @(negedge mclk)
	begin
		sCnt <= reqIn.startIn ? HOLD_CYCLES : (sCnt > 0 ? sCnt - 1 : 0);
		rCnt <= reqIn.resetIn ? HOLD_CYCLES : (rCnt > 0 ? rCnt - 1 : 0);
		pins_r.startIn <= reqIn.startIn || sCnt > 1;
		pins_r.resetIn <= reqIn.resetIn || rCnt > 1;
		pins_r.gateIn <= reqIn.gateIn;
	end
endmodule

// file: test/mdt_core_tb_top.sv
`timescale 1ns/1ps
module mdt_core_tb_top
	import mdt_pkg::*;
;
	logic                 mclk = 1'b0;
	logic                 rst_b = 1'b0;
	mdt_pins_s            req = '0;
	mdt_pins_s            pinsIn;
	mdt_cfg_s             cfgIn = '0;
	logic                 ctrlOut;
	logic [ELAPSED_W-1:0] elapsedTime;
	logic [ELAPSED_W-1:0] held;
	logic [ELAPSED_W-1:0] maxSeen;
	logic [SET_W-1:0]     t1;
	logic [31:0]          seed = 32'h00000027;
	int                   mismatches = 0;
	int                   nCompared = 0;
	int                   cycles = 0;
	int                   rises;
	mdt_switch_model sw_u (.mclk(mclk), .reqIn(req), .pinsOut(pinsIn));
	mdt_core #(.TICK_CYCLES(4)) dut_u (.mclk(mclk), .rst_b(rst_b), .pinsIn(pinsIn),
		.cfgIn(cfgIn), .ctrlOut(ctrlOut), .elapsedTime(elapsedTime));
	initial forever #50 mclk = ~mclk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic end_sim();
		if (mismatches == 0 && nCompared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			mismatches++;
			end_sim();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic chkVal(input logic [ELAPSED_W-1:0] got, input logic [ELAPSED_W-1:0] exp);
		nCompared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t value %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic chkBit(input logic got, input logic exp);
		nCompared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t output %b expected %b", $time, got, exp);
		end
	endtask
	task automatic waitE(input logic [ELAPSED_W-1:0] v);
		int n = 0;
		while (elapsedTime !== v && n < 400)
		begin
			cyc(1);
			n++;
		end
		chkVal(elapsedTime, v);
	endtask
	task automatic pulse(input logic isReset);
		if (isReset) req.resetIn <= 1'b1; else req.startIn <= 1'b1;
		cyc(1);
		req.resetIn <= 1'b0;
		req.startIn <= 1'b0;
		cyc(6);
	endtask
	task automatic watch(input int n);
		logic prev;
		prev = ctrlOut;
		rises = 0;
		maxSeen = '0;
		repeat (n)
		begin
			cyc(1);
			if (ctrlOut === 1'b1 && prev === 1'b0) rises++;
			if (elapsedTime > maxSeen) maxSeen = elapsedTime;
			prev = ctrlOut;
		end
	endtask
	initial
	begin
		cyc(10);
		rst_b <= 1'b1;
		cyc(2);
		for (int i = 0; i < 3; i++)
		begin
			seed = xs(seed);
			t1 = SET_W'(seed % 5 + 1);
			cfgIn <= '{MODE_ON_DELAY, t1, 16'h0000};
			pulse(1'b0);
			chkVal(elapsedTime, ELAPSED_ZERO);
			waitE(ELAPSED_W'(t1 - 16'h0001));
			chkBit(ctrlOut, 1'b0);
			waitE(ELAPSED_W'(t1));
			cyc(2);
			chkBit(ctrlOut, 1'b1);
		end
		req.gateIn <= 1'b1;
		pulse(1'b1);
		chkBit(ctrlOut, 1'b0);
		chkVal(elapsedTime, ELAPSED_ZERO);
		cfgIn <= '{MODE_ON_DELAY, 16'h0014, 16'h0000};
		pulse(1'b0);
		req.gateIn <= 1'b0;
		waitE(17'h00003);
		req.gateIn <= 1'b1;
		cyc(4);
		held = elapsedTime;
		cyc(20);
		chkVal(elapsedTime, held);
		req.gateIn <= 1'b0;
		waitE(held + ELAPSED_ONE);
		pulse(1'b1);
		cyc(20);
		chkVal(elapsedTime, ELAPSED_ZERO);
		cfgIn <= '{MODE_ON_DELAY, 16'h0000, 16'h0000};
		pulse(1'b0);
		chkBit(ctrlOut, 1'b1);
		cfgIn <= '{MODE_INTERVAL, 16'h0003, 16'h0000};
		pulse(1'b0);
		chkBit(ctrlOut, 1'b1);
		waitE(17'h00003);
		cyc(2);
		chkBit(ctrlOut, 1'b0);
		cfgIn <= '{MODE_ONE_SHOT, 16'h0002, 16'h0003};
		req.startIn <= 1'b1;
		watch(80);
		chkVal(ELAPSED_W'(rises), ELAPSED_ONE);
		req.startIn <= 1'b0;
		// The held start must fall and clear the synchroniser, or the next start has no edge.
		cyc(8);
		cfgIn <= '{MODE_FLICKER, 16'h0002, 16'h0003};
		pulse(1'b0);
		watch(80);
		chkVal(maxSeen, 17'h00005);
		// A period of five ticks of four cycles gives four rises in the 80-cycle window.
		chkVal(ELAPSED_W'(rises), 17'h00004);
		end_sim();
	end
endmodule
